// [verilog/partner_ability_consts.svh]
// constants for the link partner ability register block
// assumes inclusion by bare name from the design files
`ifndef PARTNER_ABILITY_CONSTS_SVH
`define PARTNER_ABILITY_CONSTS_SVH

`define PA_ADDR_W 5
`define PA_DATA_W 16
`define PA_ADDR_PARTNER_ABILITY 5'h05
`define PA_RESET_VALUE 16'h0000
`define PA_BIT_NEXT_PAGE 15
`define PA_BIT_ACK 14
`define PA_BIT_FAULT_OR_MSG 13
`define PA_BIT_RSVD_OR_COMPLY 12
`define PA_BIT_ASYM_OR_TOGGLE 11
`define PA_BIT_PAUSE 10
`define PA_TECH_HI 9
`define PA_TECH_LO 5
`define PA_SEL_HI 4
`define PA_SEL_LO 0
`define PA_CODE_HI 10
`define PA_CODE_LO 0
`define PA_READ_LATENCY 1

`endif

// [verilog/partner_ability_pkg.sv]
// types shared by the link partner ability register block
// assumes nothing beyond a SystemVerilog compiler
package partner_ability_pkg;
    typedef enum logic {
        VIEW_BASE,
        VIEW_NEXT
    } page_view_t;
endpackage

// [verilog/page_capture.sv]
// captures received pages into the base or next-page image
// assumes page_valid pulses once per page from the negotiation engine
`timescale 1ns/1ps
`include "partner_ability_consts.svh"
module page_capture
    import partner_ability_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // received page
    input wire logic page_valid,
    input wire logic page_is_next,
    input wire logic [15:0] page_word,
    // captured image
    output logic [15:0] image_reg,
    output page_view_t view_reg
);
    logic [15:0] base_clean;

    always_comb begin
        base_clean = page_word;
        base_clean[`PA_BIT_RSVD_OR_COMPLY] = 1'b0; // RULE6
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            image_reg <= `PA_RESET_VALUE; // RULE15
        end else if (page_valid) begin
            // whole word replaced: next page supersedes base page
            image_reg <= page_is_next ? page_word : base_clean; // RULE2
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            view_reg <= VIEW_BASE; // RULE15
        end else if (page_valid) begin
            view_reg <= page_is_next ? VIEW_NEXT : VIEW_BASE; // RULE2
        end
    end

    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (srst) // RULE6
        (view_reg == VIEW_BASE) |-> !image_reg[`PA_BIT_RSVD_OR_COMPLY])
        else $error("reserved bit set in base view");
endmodule

// [verilog/mgmt_read_port.sv]
// one-cycle read data port for the management register
// assumes strobes are single cycle and never overlap
`timescale 1ns/1ps
`include "partner_ability_consts.svh"
module mgmt_read_port (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // request
    input wire logic rd_stb,
    input wire logic [4:0] addr,
    input wire logic [15:0] image,
    // answer
    output logic [15:0] rd_data_reg,
    output logic rd_valid_reg
);
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_reg <= `PA_RESET_VALUE;
        end else if (rd_stb && addr == `PA_ADDR_PARTNER_ABILITY) begin
            rd_data_reg <= image; // RULE1
        end else begin
            // unmapped or idle reads return zero
            rd_data_reg <= 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_stb;
        end
    end
endmodule

// [verilog/link_partner_ability_register.sv]
// link partner ability register at management address 0x05
// assumes negotiation engine pulses page_valid with the received word
//
// Notes on behaviour
// RULE1 - address 0x05 shows received partner ability
// RULE2 - next page replaces base page after completion
// RULE3 - bit 15 is partner next page request
// RULE4 - bit 14 is partner acknowledge, engine driven
// RULE5 - base bit 13 is partner remote fault
// RULE6 - base bit 12 reserved, reads zero
// RULE7 - base bits 11,10 asymmetric pause, pause
// RULE8 - bits 9..5 partner technology abilities; decoded only in the base view, zero in the next view
// RULE9 - base bits 4:0 partner selector
// RULE10 - next bit 13 marks message page
// RULE11 - next bit 12 partner can comply
// RULE12 - next bit 11 is toggle indication
// RULE13 - next bits 10:0 hold code field
// RULE14 - management writes change nothing
// RULE15 - reset clears both views to zero
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "partner_ability_consts.svh"
module link_partner_ability_register
    import partner_ability_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // management port
    input wire logic [4:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rd_data,
    // from negotiation engine
    input wire logic page_valid,
    input wire logic page_is_next,
    input wire logic [15:0] page_word,
    // decoded partner status
    output logic next_page_request,
    output logic partner_ack,
    output logic partner_remote_fault,
    output logic asymmetric_pause_ability,
    output logic partner_pause_ability,
    output logic partner_four_pair_ability,
    output logic partner_fast_full_duplex,
    output logic partner_fast_ability,
    output logic partner_ten_full_duplex,
    output logic partner_ten_ability,
    output logic [4:0] partner_selector,
    output logic message_page_flag,
    output logic partner_comply_ability,
    output logic partner_toggle,
    output logic [10:0] partner_code,
    output logic next_view
);
    logic [15:0] partner_ability_reg;
    page_view_t view_reg;
    logic [15:0] rd_data_reg;
    logic base_v;
    logic next_v;
    logic [15:0] w;

    // writes deliberately unused: register is read only
    page_capture u_capture (
        .clk(clk),
        .srst(srst),
        .page_valid(page_valid),
        .page_is_next(page_is_next),
        .page_word(page_word),
        .image_reg(partner_ability_reg),
        .view_reg(view_reg)
    ); // RULE14

    mgmt_read_port u_read (
        .clk(clk),
        .srst(srst),
        .rd_stb(rd_stb),
        .addr(addr),
        .image(partner_ability_reg),
        .rd_data_reg(rd_data_reg),
        .rd_valid_reg()
    );

    assign rd_data = rd_data_reg; // RULE1

    // decoded outputs registered from the next-state image
    always_comb begin
        w = partner_ability_reg;
        if (page_valid) begin
            w = page_word;
            if (!page_is_next) begin
                w[`PA_BIT_RSVD_OR_COMPLY] = 1'b0;
            end
        end
        base_v = page_valid ? !page_is_next : (view_reg == VIEW_BASE);
        next_v = !base_v;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            next_page_request <= 1'b0;
            partner_ack <= 1'b0;
        end else begin
            next_page_request <= w[`PA_BIT_NEXT_PAGE]; // RULE3
            partner_ack <= w[`PA_BIT_ACK]; // RULE4
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            partner_remote_fault <= 1'b0;
            asymmetric_pause_ability <= 1'b0;
            partner_pause_ability <= 1'b0;
            partner_selector <= 5'h00;
        end else begin
            partner_remote_fault <= base_v & w[`PA_BIT_FAULT_OR_MSG]; // RULE5
            asymmetric_pause_ability <= base_v & w[`PA_BIT_ASYM_OR_TOGGLE]; // RULE7
            partner_pause_ability <= base_v & w[`PA_BIT_PAUSE]; // RULE7
            partner_selector <= base_v ? w[`PA_SEL_HI:`PA_SEL_LO] : 5'h00; // RULE9
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            partner_four_pair_ability <= 1'b0;
            partner_fast_full_duplex <= 1'b0;
            partner_fast_ability <= 1'b0;
            partner_ten_full_duplex <= 1'b0;
            partner_ten_ability <= 1'b0;
        end else begin
            partner_four_pair_ability <= base_v & w[9]; // RULE8
            partner_fast_full_duplex <= base_v & w[8]; // RULE8
            partner_fast_ability <= base_v & w[7]; // RULE8
            partner_ten_full_duplex <= base_v & w[6]; // RULE8
            partner_ten_ability <= base_v & w[5]; // RULE8
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            message_page_flag <= 1'b0;
            partner_comply_ability <= 1'b0;
            partner_toggle <= 1'b0;
            partner_code <= 11'h000;
            next_view <= 1'b0;
        end else begin
            message_page_flag <= next_v & w[`PA_BIT_FAULT_OR_MSG]; // RULE10
            partner_comply_ability <= next_v & w[`PA_BIT_RSVD_OR_COMPLY]; // RULE11
            partner_toggle <= next_v & w[`PA_BIT_ASYM_OR_TOGGLE]; // RULE12
            partner_code <= next_v ? w[`PA_CODE_HI:`PA_CODE_LO] : 11'h000; // RULE13
            next_view <= next_v; // RULE2
        end
    end

    // named steps shared by the checks below
    sequence page_in_s;
        page_valid;
    endsequence

    sequence base_in_s;
        page_valid && !page_is_next;
    endsequence

    sequence next_in_s;
        page_valid && page_is_next;
    endsequence

    sequence rd_here_s;
        rd_stb && addr == `PA_ADDR_PARTNER_ABILITY;
    endsequence

    sequence rd_miss_s;
        !(rd_stb && addr == `PA_ADDR_PARTNER_ABILITY);
    endsequence

    // the answer must be gone once the strobe has dropped
    sequence rd_then_idle_s;
        rd_here_s ##1 !rd_stb;
    endsequence

    // a read right behind a capture must already see the new word
    sequence next_then_rd_s;
        next_in_s ##1 rd_here_s;
    endsequence

    sequence base_then_rd_s;
        base_in_s ##1 rd_here_s;
    endsequence

    // reset edges left out: sync reset drops by the same edge it acts on
    sequence quiet_s;
        !page_valid && !srst;
    endsequence

    // management side
    AST_READ_DATA: assert property (@(posedge clk) disable iff (srst) // RULE1
        rd_here_s |=> rd_data == $past(partner_ability_reg))
        else $error("read data differs from register");

    AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (srst) // RULE1
        rd_then_idle_s |=> rd_data == 16'h0000)
        else $error("read data stood longer than one cycle");

    AST_READ_MISS_ZERO: assert property (@(posedge clk) disable iff (srst) // RULE1
        rd_miss_s |=> rd_data == 16'h0000)
        else $error("unmapped or idle read not zero");

    AST_READ_AFTER_NEXT: assert property (@(posedge clk) disable iff (srst) // RULE2
        next_then_rd_s |=> rd_data == $past(page_word, 2))
        else $error("read after next page shows stale word");

    AST_READ_AFTER_BASE: assert property (@(posedge clk) disable iff (srst) // RULE6
        base_then_rd_s |=> rd_data == ($past(page_word, 2) & 16'hefff))
        else $error("read after base page shows wrong word");

    // capture and view selection
    AST_NEXT_REPLACE: assert property (@(posedge clk) disable iff (srst) // RULE2
        page_in_s ##0 page_is_next |=> partner_ability_reg == $past(page_word))
        else $error("next page not captured");

    AST_VIEW_FOLLOWS: assert property (@(posedge clk) disable iff (srst) // RULE2
        page_in_s |=> next_view == $past(page_is_next))
        else $error("view flag does not follow page kind");

    AST_BASE_HIDDEN: assert property (@(posedge clk) disable iff (srst) // RULE2
        next_view |-> !partner_remote_fault && !asymmetric_pause_ability
        && !partner_pause_ability && partner_selector == 5'h00)
        else $error("base fields shown in next view");

    AST_NEXT_HIDDEN: assert property (@(posedge clk) disable iff (srst) // RULE2
        !next_view |-> !message_page_flag && !partner_comply_ability
        && !partner_toggle && partner_code == 11'h000)
        else $error("next fields shown in base view");

    // fields common to both views
    AST_NP_BIT: assert property (@(posedge clk) disable iff (srst) // RULE3
        page_in_s |=> next_page_request == $past(page_word[15]))
        else $error("next page request wrong");

    AST_ACK_CAPTURE: assert property (@(posedge clk) disable iff (srst) // RULE4
        page_in_s |=> partner_ack == $past(page_word[14]))
        else $error("ack not taken from page");

    // acknowledge moves only with a received page, never on its own
    AST_ACK_BIT: assert property (@(posedge clk) disable iff (srst) // RULE4
        quiet_s |=> $stable(partner_ack))
        else $error("ack changed without a page");

    // base-page fields
    AST_FAULT: assert property (@(posedge clk) disable iff (srst) // RULE5
        page_in_s ##0 !page_is_next |=> partner_remote_fault == $past(page_word[13]))
        else $error("remote fault wrong");

    AST_RSVD_READ: assert property (@(posedge clk) disable iff (srst) // RULE6
        rd_here_s ##0 view_reg == VIEW_BASE |=> !rd_data[12])
        else $error("reserved bit read as one");

    AST_RSVD_IMAGE: assert property (@(posedge clk) disable iff (srst) // RULE6
        base_in_s |=> !partner_ability_reg[`PA_BIT_RSVD_OR_COMPLY])
        else $error("reserved bit captured as one");

    AST_PAUSE_BITS: assert property (@(posedge clk) disable iff (srst) // RULE7
        base_in_s |=> asymmetric_pause_ability == $past(page_word[11])
        && partner_pause_ability == $past(page_word[10]))
        else $error("pause bits wrong");

    AST_TECH: assert property (@(posedge clk) disable iff (srst) // RULE8
        page_in_s ##0 !page_is_next |=> partner_four_pair_ability == $past(page_word[9])
        && partner_ten_ability == $past(page_word[5]))
        else $error("technology bits wrong");

    AST_TECH_FAST: assert property (@(posedge clk) disable iff (srst) // RULE8
        base_in_s |=> partner_fast_full_duplex == $past(page_word[8])
        && partner_fast_ability == $past(page_word[7])
        && partner_ten_full_duplex == $past(page_word[6]))
        else $error("duplex technology bits wrong");

    AST_SELECTOR: assert property (@(posedge clk) disable iff (srst) // RULE9
        base_in_s |=> partner_selector == $past(page_word[4:0]))
        else $error("selector wrong");

    // next-page fields
    AST_MSG_PAGE: assert property (@(posedge clk) disable iff (srst) // RULE10
        next_in_s |=> message_page_flag == $past(page_word[13]))
        else $error("message page flag wrong");

    AST_COMPLY: assert property (@(posedge clk) disable iff (srst) // RULE11
        next_in_s |=> partner_comply_ability == $past(page_word[12]))
        else $error("comply bit wrong");

    AST_TOGGLE: assert property (@(posedge clk) disable iff (srst) // RULE12
        next_in_s |=> partner_toggle == $past(page_word[11]))
        else $error("toggle bit wrong");

    AST_CODE: assert property (@(posedge clk) disable iff (srst) // RULE13
        next_in_s |=> partner_code == $past(page_word[10:0]))
        else $error("code field wrong");

    // management writes and reset
    AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (srst) // RULE14
        wr_stb && !page_valid && !srst |=> $stable(partner_ability_reg))
        else $error("write changed register");

    AST_DECODE_HOLDS: assert property (@(posedge clk) disable iff (srst) // RULE14
        quiet_s |=> $stable(partner_code) && $stable(partner_selector)
        && $stable(next_view))
        else $error("decoded field moved without a page");

    AST_RESET_CLEAR: assert property (@(posedge clk) // RULE15
        srst |=> partner_ability_reg == 16'h0000 && partner_code == 11'h000)
        else $error("reset did not clear");

    AST_RESET_OUTS: assert property (@(posedge clk) // RULE15
        srst |=> !next_view && !next_page_request && !partner_ack
        && partner_selector == 5'h00 && rd_data == 16'h0000)
        else $error("reset left an output set");
endmodule

// [sim/test_link_partner_ability_register.sv]
// self-checking bench for the link partner ability register
// assumes the design files are compiled first; the bench drives every port itself
`timescale 1ns/1ps
`include "partner_ability_consts.svh"
module test_link_partner_ability_register;
    logic clk, srst, wr_stb, rd_stb, page_valid, page_is_next;
    logic [4:0] addr;
    logic [15:0] wr_data, rd_data, page_word;
    logic next_page_request, partner_ack, partner_remote_fault, asymmetric_pause_ability;
    logic partner_pause_ability, partner_four_pair_ability, partner_fast_full_duplex;
    logic partner_fast_ability, partner_ten_full_duplex, partner_ten_ability;
    logic message_page_flag, partner_comply_ability, partner_toggle, next_view;
    logic [4:0] partner_selector;
    logic [10:0] partner_code;
    logic [14:0] base_vec;
    logic [13:0] next_vec;
    int fail_count = 0;
    int total_checks = 0;

    // decoded outputs packed in register bit order, base bit 12 left out
    assign base_vec = {next_page_request, partner_ack, partner_remote_fault,
        asymmetric_pause_ability, partner_pause_ability, partner_four_pair_ability,
        partner_fast_full_duplex, partner_fast_ability, partner_ten_full_duplex,
        partner_ten_ability, partner_selector};
    assign next_vec = {message_page_flag, partner_comply_ability, partner_toggle, partner_code};

    link_partner_ability_register DUT (
        .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .page_valid(page_valid),
        .page_is_next(page_is_next), .page_word(page_word),
        .next_page_request(next_page_request), .partner_ack(partner_ack),
        .partner_remote_fault(partner_remote_fault),
        .asymmetric_pause_ability(asymmetric_pause_ability),
        .partner_pause_ability(partner_pause_ability),
        .partner_four_pair_ability(partner_four_pair_ability),
        .partner_fast_full_duplex(partner_fast_full_duplex),
        .partner_fast_ability(partner_fast_ability),
        .partner_ten_full_duplex(partner_ten_full_duplex),
        .partner_ten_ability(partner_ten_ability), .partner_selector(partner_selector),
        .message_page_flag(message_page_flag), .partner_comply_ability(partner_comply_ability),
        .partner_toggle(partner_toggle), .partner_code(partner_code), .next_view(next_view)
    );

    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic mgmt_read(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic mgmt_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic send_page(input logic is_next, input logic [15:0] w);
        @(posedge clk);
        page_valid <= 1'b1;
        page_is_next <= is_next;
        page_word <= w;
        @(posedge clk);
        page_valid <= 1'b0;
        #1;
    endtask

    task automatic expect_cleared();
        logic [15:0] d;
        check({1'b0, base_vec}, 16'h0000);
        check({2'b00, next_vec}, 16'h0000);
        check({15'h0, next_view}, 16'h0000);
        mgmt_read(`PA_ADDR_PARTNER_ABILITY, d);
        check(d, `PA_RESET_VALUE);
    endtask

    task automatic base_pages();
        logic [15:0] words [2] = '{16'hf5aa, 16'h0a55};
        logic [15:0] w;
        logic [15:0] d;
        foreach (words[i]) begin
            w = words[i];
            send_page(1'b0, w);
            check({13'h0, base_vec[14:12]}, {13'h0, w[15:13]});
            check({9'h0, base_vec[11:5]}, {9'h0, w[11:5]});
            check({11'h0, base_vec[4:0]}, {11'h0, w[4:0]});
            check({2'b00, next_vec}, 16'h0000);
            check({15'h0, next_view}, 16'h0000);
            mgmt_read(`PA_ADDR_PARTNER_ABILITY, d);
            check(d, words[i] & 16'hefff);
        end
    endtask

    task automatic writes_and_unmapped();
        logic [15:0] d;
        mgmt_write(`PA_ADDR_PARTNER_ABILITY, 16'hffff);
        mgmt_write(5'h04, 16'hffff);
        mgmt_read(`PA_ADDR_PARTNER_ABILITY, d);
        check(d, 16'h0a55);
        @(posedge clk);
        #1;
        check(rd_data, 16'h0000);
        mgmt_read(5'h04, d);
        check(d, 16'h0000);
        mgmt_read(5'h1f, d);
        check(d, 16'h0000);
    endtask

    task automatic next_pages();
        logic [15:0] words [2] = '{16'hb6c3, 16'h493c};
        logic [15:0] d;
        foreach (words[i]) begin
            send_page(1'b1, words[i]);
            check({2'b00, next_vec}, {2'b00, words[i][13:0]});
            check({1'b0, base_vec}, {1'b0, words[i][15:14], 13'h0});
            check({15'h0, next_view}, 16'h0001);
            mgmt_read(`PA_ADDR_PARTNER_ABILITY, d);
            check(d, words[i]);
        end
    endtask

    task automatic page_during_read();
        logic [15:0] w = 16'h7e81;
        logic [15:0] d;
        // read and base page on one edge: read still sees the last next page
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= `PA_ADDR_PARTNER_ABILITY;
        page_valid <= 1'b1;
        page_is_next <= 1'b0;
        page_word <= w;
        @(posedge clk);
        rd_stb <= 1'b0;
        page_valid <= 1'b0;
        #1;
        check(rd_data, 16'h493c);
        check({15'h0, next_view}, 16'h0000);
        check({13'h0, base_vec[14:12]}, {13'h0, w[15:13]});
        check({2'b00, next_vec}, 16'h0000);
        mgmt_read(`PA_ADDR_PARTNER_ABILITY, d);
        check(d, w & 16'hefff);
    endtask

    task automatic mid_reset();
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        expect_cleared();
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    initial begin
        srst = 1'b1;
        addr = 5'h00;
        wr_data = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        page_valid = 1'b0;
        page_is_next = 1'b0;
        page_word = 16'h0000;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        #1;
        expect_cleared();
        base_pages();
        writes_and_unmapped();
        next_pages();
        page_during_read();
        mid_reset();
        stop_test();
    end
endmodule
